/* File: core/param_cmd_map.vh */
// constants for the parameter-access command interpreter
// included by param_cmd.v; definitions only
`ifndef PARAM_CMD_MAP_VH
`define PARAM_CMD_MAP_VH
// instruction codes
`define OP_GET_AXIS       8'h06
`define OP_STORE_AXIS     8'h07
`define OP_RESTORE_AXIS   8'h08
`define OP_SET_GLOBAL     8'h09
`define OP_GET_GLOBAL     8'h0A
`define OP_STORE_GLOBAL   8'h0B
// banks and fixed selectors
`define BANK_SETTINGS     8'h00
`define BANK_USER         8'h02
`define BANK_IRQ          8'h03
`define AXIS_ONLY         8'h00
`define PARAM_SER_ADDR    8'h42
// reply status codes
`define ST_OK             8'h64
`define ST_BAD_CHECKSUM   8'h01
`define ST_BAD_COMMAND    8'h02
`define ST_BAD_TYPE       8'h03
`define ST_BAD_VALUE      8'h04
// frame layout and reset values
`define FRAME_BYTES       4'h9
`define SER_ADDR_RESET    8'h01
`define ACCU_RESET        32'h00000000
`endif

/* File: core/param_cmd.v */
// parameter-access command interpreter: frame intake, checksum, parameter
// tables for one axis and banks 0/2/3, nonvolatile shadow copies.
// assumes bytes arrive one per rx_valid pulse, synchronous to core_clk,
// and that only one frame is in flight until reply_valid is seen.
`timescale 1ns/1ps
`default_nettype none
`include "param_cmd_map.vh"
// Function
// - get axis param loads accumulator in program
// - direct mode get axis param leaves accumulator unchanged
// - successful gets reply status 100 plus value
// - axis param chosen by type, axis 0
// - store axis param copies value to eeprom
// - restore axis param reloads from eeprom copy
// - power-up reloads all axis params from eeprom
// - user variables auto-restored if configured
// - set global param writes value field
// - bank must be 0, 2 or 3
// - bank 0 writes commit to eeprom automatically
// - serial address is bank 0 parameter 66
// - get global param copies into accumulator
// - store global persists bank 2 variables
// - store global uses instruction code 11
module param_cmd (
  // clock and reset
  input  wire        core_clk,
  input  wire        reset_n,
  // command byte stream
  input  wire        rx_valid,
  input  wire [7:0]  rx_byte,
  // mode and configuration straps
  input  wire        program_mode,
  input  wire        user_autorestore,
  // reply
  output reg         reply_valid,
  output reg  [7:0]  reply_status,
  output reg  [31:0] reply_value,
  output reg  [7:0]  reply_op,
  // state views
  output reg  [31:0] accu,
  output reg  [7:0]  ser_addr,
  output reg         init_done
);
  // table state: 256 axis params, 256 per bank, with shadow copies
  reg [31:0] axis_q   [0:255];   // live axis parameters
  reg [31:0] axis_nv  [0:255];   // eeprom copy of axis parameters
  reg [31:0] glob_q   [0:767];   // live globals, bank index in top bits
  reg [31:0] glob_nv  [0:767];   // eeprom copy of globals
  // frame assembly
  reg [7:0]  frame_q  [0:7];     // bytes 0..7 of the frame
  reg [3:0]  cnt_q;              // bytes received so far
  reg [7:0]  sum_q;              // running checksum
  // power-up reload sweep
  reg [7:0]  init_idx_q;         // entry being reloaded
  // decoded fields of the finished frame
  // valid only at the ninth byte; in between they show stale bytes
  wire [7:0]  f_op    = frame_q[1];
  wire [7:0]  f_type  = frame_q[2];
  wire [7:0]  f_bank  = frame_q[3];
  wire [31:0] f_val   = {frame_q[4], frame_q[5], frame_q[6], frame_q[7]};
  wire        last_b  = rx_valid && (cnt_q == `FRAME_BYTES - 4'h1);
  wire        sum_ok  = (sum_q == rx_byte);
  wire        bank_ok = (f_bank == `BANK_SETTINGS) || (f_bank == `BANK_USER) ||
                        (f_bank == `BANK_IRQ);
  // banks 0/2/3 fold onto three 256-entry slices of the global table
  wire [1:0]  bsel    = (f_bank == `BANK_SETTINGS) ? 2'h0 :
                        (f_bank == `BANK_USER) ? 2'h1 : 2'h2;
  wire [9:0]  gidx    = {bsel, f_type};
  wire        axis_ok = (f_bank == `AXIS_ONLY);
  // note: tables are held without reset, like the parameter ram they model;
  // the reload sweep gives the axis table defined contents after reset.
  // the eeprom copies are plain arrays here; a real part would put a slow
  // nonvolatile write engine behind them, which this slice leaves out

  // frame byte collection and checksum accumulation
  // the checksum byte itself is never added: on the ninth byte the sum of
  // bytes 0..7 is compared and the counter rewinds for the next frame
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      // idle: the next byte is a target address
      cnt_q <= 4'h0;
      sum_q <= 8'h00;
    end else if (rx_valid && init_done) begin
      if (last_b) begin
        // ninth byte: frame ends, a new one may follow at once
        cnt_q <= 4'h0;
        sum_q <= 8'h00;
      end else begin
        // bytes 0..7 are counted and feed the modulo-256 sum
        cnt_q <= cnt_q + 4'h1;
        sum_q <= sum_q + rx_byte;
      end
    end
  end

  // frame storage; bytes arriving during the power-up sweep are dropped
  // no reset needed: fields are decoded only on the ninth byte, by which
  // time all eight slots hold bytes of that same frame
  always @(posedge core_clk) begin
    if (rx_valid && init_done && !last_b)
      frame_q[cnt_q[2:0]] <= rx_byte;
  end

  // power-up sweep: restore axis and, if configured, user variables
  // one entry per clock, so commands are held off for 256 cycles after
  // reset; a host that sends earlier loses those bytes
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      init_idx_q <= 8'h00;
      init_done  <= 1'b0;
    end else if (!init_done) begin
      init_idx_q <= init_idx_q + 8'h01;
      // last entry is written this cycle: open the command path
      if (init_idx_q == 8'hFF)
        init_done <= 1'b1;
    end
  end

  // table writes: sweep, restores, stores and global sets
  // a frame with a bad checksum writes nothing; the reply process alone
  // reports the refusal
  always @(posedge core_clk) begin
    if (!init_done) begin
      // sweep has priority; no frame can end while it runs
      axis_q[init_idx_q] <= axis_nv[init_idx_q];
      if (user_autorestore)
        glob_q[{2'h1, init_idx_q}] <= glob_nv[{2'h1, init_idx_q}];
    end else if (last_b && sum_ok) begin
      case (f_op)
        `OP_STORE_AXIS: begin
          if (axis_ok)
            axis_nv[f_type] <= axis_q[f_type];
        end
        `OP_RESTORE_AXIS: begin
          if (axis_ok)
            axis_q[f_type] <= axis_nv[f_type];
        end
        `OP_SET_GLOBAL: begin
          if (bank_ok) begin
            glob_q[gidx] <= f_val;
            if (f_bank == `BANK_SETTINGS)
              glob_nv[gidx] <= f_val;
          end
        end
        `OP_STORE_GLOBAL: begin
          if (bank_ok)
            glob_nv[gidx] <= glob_q[gidx];
        end
        default: begin
          // gets and unknown codes leave the tables alone
        end
      endcase
    end
  end

  // serial address mirror of bank 0 parameter 66
  // only the low byte is kept; the global table still holds all 32 bits
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n)
      ser_addr <= `SER_ADDR_RESET;
    else if (last_b && sum_ok && init_done && f_op == `OP_SET_GLOBAL &&
             f_bank == `BANK_SETTINGS && f_type == `PARAM_SER_ADDR)
      ser_addr <= f_val[7:0];
  end

  // reply and accumulator; status 100 on success, error codes otherwise
  // reply_valid is a one-cycle pulse; status, value and op stand until the
  // next reply so a slow host may read them late
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      reply_valid  <= 1'b0;
      reply_status <= 8'h00;
      reply_value  <= 32'h00000000;
      reply_op     <= 8'h00;
      accu         <= `ACCU_RESET;
    end else begin
      reply_valid <= 1'b0;
      if (last_b && init_done) begin
        reply_valid  <= 1'b1;
        reply_op     <= f_op;
        reply_value  <= 32'h00000000;
        reply_status <= `ST_OK;
        // a corrupt frame is refused before its op is looked at
        if (!sum_ok) begin
          reply_status <= `ST_BAD_CHECKSUM;
        end else begin
          case (f_op)
            `OP_GET_AXIS: begin
              if (!axis_ok)
                reply_status <= `ST_BAD_VALUE;
              else begin
                reply_value <= axis_q[f_type];
                if (program_mode)
                  accu <= axis_q[f_type];
              end
            end
            `OP_STORE_AXIS, `OP_RESTORE_AXIS: begin
              if (!axis_ok)
                reply_status <= `ST_BAD_VALUE;
            end
            `OP_SET_GLOBAL, `OP_STORE_GLOBAL: begin
              if (!bank_ok)
                reply_status <= `ST_BAD_VALUE;
            end
            `OP_GET_GLOBAL: begin
              if (!bank_ok)
                reply_status <= `ST_BAD_VALUE;
              else begin
                reply_value <= glob_q[gidx];
                accu        <= glob_q[gidx];
              end
            end
            // codes outside 6..11 belong to other command slices
            default: reply_status <= `ST_BAD_COMMAND;
          endcase
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: testbench/host_model.sv */
// host side: sends nine-byte command frames into the interpreter
// assumes the interpreter samples bytes on the rising clock edge
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // clock
  input  wire logic       core_clk,
  // byte stream
  output var  logic       rx_valid,
  output var  logic [7:0] rx_byte
);
  initial begin
    rx_valid = 1'b0;
    rx_byte  = 8'h00;
  end
  // one frame, back to back; bad flips the checksum to provoke a refusal
  task automatic send(input logic [7:0] op, typ, bank, input logic [31:0] val, input logic bad);
    logic [7:0] b [0:8];
    integer i;
    b[0] = 8'h01; // target address, not checked
    b[1] = op;
    b[2] = typ;
    b[3] = bank;
    b[4] = val[31:24];
    b[5] = val[23:16];
    b[6] = val[15:8];
    b[7] = val[7:0];
    b[8] = 8'h00;
    for (i = 0; i < 8; i++) b[8] = b[8] + b[i];
    if (bad) b[8] = ~b[8];
    for (i = 0; i < 9; i++) begin
      @(posedge core_clk);
      rx_valid <= 1'b1;
      rx_byte  <= b[i];
    end
    @(posedge core_clk);
    rx_valid <= 1'b0;
    rx_byte  <= ~b[8]; // released line must not keep the last byte
  endtask
endmodule
`default_nettype wire

/* File: testbench/param_cmd_monitor.sv */
// reply and state checks for the parameter command interpreter
// bound to param_cmd; sees its ports only
`timescale 1ns/1ps
`default_nettype none
`include "param_cmd_map.vh"
module param_cmd_monitor (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        reset_n,
  // command side
  input wire logic        rx_valid,
  input wire logic [7:0]  rx_byte,
  input wire logic        program_mode,
  input wire logic        user_autorestore,
  // reply and state
  input wire logic        reply_valid,
  input wire logic [7:0]  reply_status,
  input wire logic [31:0] reply_value,
  input wire logic [7:0]  reply_op,
  input wire logic [31:0] accu,
  input wire logic [7:0]  ser_addr,
  input wire logic        init_done
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  pulse_once_a: assert property (reply_valid |=> !reply_valid) else $error("reply held");
  status_set_a: assert property (reply_valid |-> reply_status inside {`ST_OK, `ST_BAD_CHECKSUM,
    `ST_BAD_COMMAND, `ST_BAD_VALUE}) else $error("odd status");
  gg_accu_a: assert property (reply_valid && reply_op == `OP_GET_GLOBAL && reply_status == `ST_OK
    |-> accu == reply_value) else $error("get global accu");
  ga_prog_a: assert property (reply_valid && reply_op == `OP_GET_AXIS && program_mode &&
    reply_status == `ST_OK |-> accu == reply_value) else $error("program get accu");
  ga_direct_a: assert property (reply_valid && reply_op == `OP_GET_AXIS && !program_mode
    |-> $stable(accu)) else $error("direct get moved accu");
  nocare_zero_a: assert property (reply_valid && reply_op inside {8'h07, 8'h08, 8'h09, 8'h0B}
    |-> reply_value == 32'h0) else $error("value not zero");
  addr_src_a: assert property ($changed(ser_addr) |-> reply_valid && reply_op == `OP_SET_GLOBAL
    && reply_status == `ST_OK) else $error("address moved");
  accu_src_a: assert property ($changed(accu) |-> reply_valid && reply_status == `ST_OK)
    else $error("accu moved");
  init_first_a: assert property (!init_done |-> !reply_valid) else $error("early reply");
  reply_src_a: assert property (reply_valid |-> $past(rx_valid)) else $error("reply without byte");
endmodule
bind param_cmd param_cmd_monitor mon (.core_clk, .reset_n, .rx_valid, .program_mode,
  .user_autorestore, .rx_byte, .reply_status, .reply_op, .ser_addr, .reply_valid, .init_done,
  .reply_value, .accu);
`default_nettype wire

/* File: testbench/param_cmd_test.sv */
// self-checking bench for the parameter command interpreter
// host_model drives frames; replies judged here
`timescale 1ns/1ps
`default_nettype none
`include "param_cmd_map.vh"
module param_cmd_test;
  logic core_clk = 1'b0, reset_n = 1'b0, program_mode = 1'b0, user_autorestore = 1'b1;
  wire rx_valid, reply_valid, init_done;
  wire [7:0] rx_byte, reply_status, reply_op, ser_addr;
  wire [31:0] reply_value, accu;
  integer miscompares = 0, n_compared = 0, k;
  always #50 core_clk = ~core_clk;
  param_cmd uut (.core_clk, .reset_n, .rx_valid, .rx_byte, .program_mode,
    .user_autorestore, .reply_valid, .reply_status, .reply_value, .reply_op, .accu,
    .ser_addr, .init_done);
  host_model host (.core_clk, .rx_valid, .rx_byte);
  task check(input string what, input logic [31:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task wrap_up;
    if (miscompares == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // one command, reply awaited for at most four cycles
  task cmd(input logic [7:0] op, typ, bank, input logic [31:0] val, input logic bad,
    input logic [7:0] st, input logic [31:0] xv, input logic cv);
    host.send(op, typ, bank, val, bad);
    for (k = 0; k < 4; k++) begin
      @(negedge core_clk);
      if (reply_valid === 1'b1) break;
    end
    check("reply", 1, reply_valid);
    if (reply_valid !== 1'b1) wrap_up;
    check("status", st, reply_status);
    if (cv) check("value", xv, reply_value);
  endtask
  task t_global;
    cmd(`OP_SET_GLOBAL, 8'h05, `BANK_USER, 32'h12345678, 0, `ST_OK, 0, 1);
    cmd(`OP_GET_GLOBAL, 8'h05, `BANK_USER, 32'hFFFFFFFF, 0, `ST_OK, 32'h12345678, 1);
    check("accu", 32'h12345678, accu);
    cmd(`OP_SET_GLOBAL, 8'h07, `BANK_IRQ, 32'hA5, 0, `ST_OK, 0, 1);
    cmd(`OP_GET_GLOBAL, 8'h07, `BANK_IRQ, 0, 0, `ST_OK, 32'hA5, 1);
    cmd(`OP_SET_GLOBAL, `PARAM_SER_ADDR, `BANK_SETTINGS, 3, 0, `ST_OK, 0, 1);
    check("ser_addr", 3, ser_addr);
    check("settings copy", 3, uut.glob_nv[66]);
    cmd(`OP_GET_GLOBAL, `PARAM_SER_ADDR, `BANK_SETTINGS, 0, 0, `ST_OK, 3, 1);
    cmd(`OP_STORE_GLOBAL, 8'h05, `BANK_USER, 0, 0, `ST_OK, 0, 1);
    check("user copy", 32'h12345678, uut.glob_nv[261]);
  endtask
  // eeprom image is poked between frames so that store and restore show up
  task t_axis;
    uut.axis_nv[4] = 32'hFFFFFFFF;
    cmd(`OP_STORE_AXIS, 8'h04, `AXIS_ONLY, 32'hDEAD, 0, `ST_OK, 0, 1);
    uut.axis_nv[5] = 32'h00005A5A;
    cmd(`OP_RESTORE_AXIS, 8'h05, `AXIS_ONLY, 32'hBEEF, 0, `ST_OK, 0, 1);
    cmd(`OP_RESTORE_AXIS, 8'h04, `AXIS_ONLY, 0, 0, `ST_OK, 0, 1);
    cmd(`OP_GET_AXIS, 8'h04, `AXIS_ONLY, 0, 0, `ST_OK, 32'h0000A11C, 1);
    check("accu", 3, accu);
    @(posedge core_clk) program_mode <= 1'b1;
    cmd(`OP_GET_AXIS, 8'h05, `AXIS_ONLY, 0, 0, `ST_OK, 32'h00005A5A, 1);
    check("accu", 32'h00005A5A, accu);
    cmd(`OP_GET_AXIS, 8'h04, 8'h01, 0, 0, `ST_BAD_VALUE, 0, 1);
  endtask
  task t_refuse;
    cmd(`OP_SET_GLOBAL, 8'h05, `BANK_USER, 32'h0BAD, 1, `ST_BAD_CHECKSUM, 0, 1);
    cmd(`OP_GET_GLOBAL, 8'h05, `BANK_USER, 0, 0, `ST_OK, 32'h12345678, 1);
    cmd(8'h05, 8'h04, `AXIS_ONLY, 0, 0, `ST_BAD_COMMAND, 0, 1);
    cmd(`OP_SET_GLOBAL, 8'h05, 8'h01, 1, 0, `ST_BAD_VALUE, 0, 1);
  endtask
  // power-up sweep must finish within its 256 cycles plus margin
  task wait_init;
    for (k = 0; k < 300 && init_done !== 1'b1; k++) @(negedge core_clk);
    check("init_done", 1, init_done);
    if (init_done !== 1'b1) wrap_up;
  endtask
  // contents reloaded by the sweep, auto-restore of user variables on
  task t_power;
    check("ser_addr", `SER_ADDR_RESET, ser_addr);
    check("accu", `ACCU_RESET, accu);
    cmd(`OP_GET_AXIS, 8'h04, `AXIS_ONLY, 0, 0, `ST_OK, 32'h0000A11C, 1);
    check("accu", `ACCU_RESET, accu);
    cmd(`OP_GET_GLOBAL, 8'h09, `BANK_USER, 0, 0, `ST_OK, 32'h00C0FFEE, 1);
  endtask
  // mid-run reset with auto-restore off: user variables keep their live value
  task t_rerun;
    cmd(`OP_SET_GLOBAL, 8'h09, `BANK_USER, 32'h00000BEE, 0, `ST_OK, 0, 1);
    @(posedge core_clk);
    reset_n          <= 1'b0;
    user_autorestore <= 1'b0;
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    wait_init;
    check("ser_addr", `SER_ADDR_RESET, ser_addr);
    check("accu", `ACCU_RESET, accu);
    cmd(`OP_GET_GLOBAL, 8'h09, `BANK_USER, 0, 0, `ST_OK, 32'h00000BEE, 1);
    cmd(`OP_GET_AXIS, 8'h04, `AXIS_ONLY, 0, 0, `ST_OK, 32'h0000A11C, 1);
  endtask
  initial begin
    uut.axis_nv[4] = 32'h0000A11C; // eeprom image reloaded by the sweep
    uut.glob_nv[265] = 32'h00C0FFEE; // bank 2 user variable 9
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    wait_init;
    t_power;
    t_global;
    t_axis;
    t_refuse;
    t_rerun;
    wrap_up;
  end
endmodule
`default_nettype wire
